// file: mmd_pkg.sv
// Constants for the memory map decode and paging block.
// Assumes a 16-bit core address bus and an 8-bit register port.
package mmd_pkg;
    // Register port
    localparam int MMD_RA_W = 8;
    localparam logic [7:0] MMD_OFS_FLASH_SIZE_INFO = 8'h00;
    localparam logic [7:0] MMD_OFS_PROGRAM_PAGE_INDEX = 8'h01;
    // Flash size info fields
    localparam int MMD_ALLOC_LSB = 6;
    localparam int MMD_SPLIT_LSB = 0;
    // Page index
    localparam int MMD_PIX_W = 6;
    localparam logic [5:0] MMD_PIX_RST_LOW = 6'h00;
    localparam logic [5:0] MMD_PIX_RST_HIGH = 6'h3C;
    // Flash allocation codes
    localparam logic [1:0] MMD_ALLOC_NONE = 2'h0;
    localparam logic [1:0] MMD_ALLOC_16K = 2'h1;
    localparam logic [1:0] MMD_ALLOC_48K = 2'h2;
    localparam logic [1:0] MMD_ALLOC_64K = 2'h3;
    // Lowest internal page per split code
    localparam logic [5:0] MMD_SPLIT0_FIRST = 6'h38;
    localparam logic [5:0] MMD_SPLIT1_FIRST = 6'h30;
    localparam logic [5:0] MMD_SPLIT2_FIRST = 6'h20;
    localparam logic [5:0] MMD_SPLIT3_FIRST = 6'h00;
    // 16K block index, address bits 15:14
    localparam logic [1:0] MMD_BLK_LOW = 2'h0;
    localparam logic [1:0] MMD_BLK_MID = 2'h1;
    localparam logic [1:0] MMD_BLK_WINDOW = 2'h2;
    localparam logic [1:0] MMD_BLK_TOP = 2'h3;
    // Register space: 1K block, port offsets within it
    localparam int MMD_REG_BLK_LSB = 10;
    localparam logic [9:0] MMD_BUS_EXP_CNT = 10'h010;
    localparam logic [9:0] MMD_OFS_PORTA = 10'h000;
    localparam logic [9:0] MMD_OFS_PORTB = 10'h001;
    localparam logic [9:0] MMD_OFS_DIRA = 10'h002;
    localparam logic [9:0] MMD_OFS_DIRB = 10'h003;
    localparam logic [9:0] MMD_OFS_PORTE = 10'h008;
    localparam logic [9:0] MMD_OFS_DIRE = 10'h009;
    localparam logic [9:0] MMD_OFS_PORTK = 10'h032;
    localparam logic [9:0] MMD_OFS_DIRK = 10'h033;
    // One select per access, one-hot
    typedef enum logic [5:0] {
        MMD_SEL_NONE = 6'b000000,
        MMD_SEL_DBG = 6'b000001,
        MMD_SEL_REG = 6'b000010,
        MMD_SEL_RAM = 6'b000100,
        MMD_SEL_EE = 6'b001000,
        MMD_SEL_FLASH = 6'b010000,
        MMD_SEL_EXT = 6'b100000
    } mmd_sel_type;
endpackage

// file: mmd_top.sv
// Memory map decode, bus steering and program paging for a 16-bit core.
// Assumes static integration straps and a CPU that holds address for one cycle.
// Summary of operation
// - Size info readable anytime, writes ignored
// - Size info mirrors integration switch inputs
// - Allocation code: none,16K,48K,64K
// - Split code: 896K/128K up to 0K/1M
// - Six index bits page 16K window 8000-BFFF
// - Reset 00 any-mode or 3C special-only
// - Bus write to index effective next cycle
// - Far call path writes index directly
// - Mux read buses, steer write data out
// - Byte swap on CPU read data
// - Decode mode and mapping into one select
// - Emulation and external chip selects generated
// - At most one select active
// - Fixed priority debug down to external
// - Paging window below all but external
// - Expanded: unclaimed external, ports A/B removed
// - Expanded with port E enable: E removed
// - Special peripheral: first 16 registers removed
// - Emulation with port K enable: K removed
// - Emulation select only for flash, K enabled
// - External select never for removed ports
// - Window internal when page at or above split threshold
`timescale 1ns/1ps
module mmd_top
    import mmd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Integration straps and modes
    input wire logic [1:0] i_flash_alloc_sel,
    input wire logic [1:0] i_offchip_split_sel,
    input wire logic i_page_reset_high,
    input wire logic i_mode_special,
    input wire logic i_mode_expanded,
    input wire logic i_mode_emulation,
    input wire logic i_mode_periph,
    input wire logic i_port_e_external_en,
    input wire logic i_port_k_external_en,
    input wire logic i_flash_upper_half_only,
    input wire logic i_flash_en,
    // Mapping contents
    input wire logic [15:0] i_reg_base,
    input wire logic i_ram_en,
    input wire logic [15:0] i_ram_base,
    input wire logic [15:0] i_ram_mask,
    input wire logic i_ee_en,
    input wire logic [15:0] i_ee_base,
    input wire logic [15:0] i_ee_mask,
    // Register port
    input wire logic [MMD_RA_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // Far call and return path
    input wire logic i_far_wr,
    input wire logic [MMD_PIX_W-1:0] i_far_wdata,
    output logic [MMD_PIX_W-1:0] o_far_rdata,
    // CPU side
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_cpu_wdata,
    input wire logic i_cpu_wr,
    input wire logic i_cpu_rd,
    input wire logic i_cpu_byte,
    input wire logic i_debug_firmware_space,
    output logic [15:0] o_cpu_rdata,
    // Incoming data buses
    input wire logic [15:0] i_dbg_rdata,
    input wire logic [15:0] i_regs_rdata,
    input wire logic [15:0] i_ram_rdata,
    input wire logic [15:0] i_ee_rdata,
    input wire logic [15:0] i_flash_rdata,
    input wire logic [15:0] i_ext_rdata,
    // Outgoing bus and selects
    output logic [15:0] o_bus_addr,
    output logic [15:0] o_bus_wdata,
    output logic o_bus_wr,
    output logic [MMD_PIX_W-1:0] o_bus_page,
    output logic [5:0] o_sel,
    output logic o_emulation_chip_sel_n,
    output logic o_external_chip_sel_n
);

    logic [MMD_PIX_W-1:0] page_index_bits_reg;
    logic [7:0] flash_size_info;
    logic page_wr_ok;
    logic [MMD_PIX_W-1:0] split_first;
    logic [9:0] reg_ofs;
    logic reg_hit, port_removed, ram_hit, ee_hit, flash_hit, win_internal;
    logic access;
    mmd_sel_type sel_next, sel_reg, rsel_reg;
    logic emul_next, xcs_next;
    logic swap_reg, byte_reg;
    logic [15:0] rmux;

    always_comb begin
        flash_size_info = '0;
        flash_size_info[MMD_ALLOC_LSB +: 2] = i_flash_alloc_sel;
        flash_size_info[MMD_SPLIT_LSB +: 2] = i_offchip_split_sel;
    end

    assign page_wr_ok = !i_page_reset_high || i_mode_special;

    // Far path wins over bus write
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            page_index_bits_reg <= i_page_reset_high ? MMD_PIX_RST_HIGH : MMD_PIX_RST_LOW;
        end else if (i_far_wr) begin
            page_index_bits_reg <= i_far_wdata;
        end else if (i_reg_wr && i_reg_addr == MMD_OFS_PROGRAM_PAGE_INDEX && page_wr_ok) begin
            page_index_bits_reg <= i_reg_wdata[MMD_PIX_W-1:0];
        end
    end

    assign o_far_rdata = page_index_bits_reg;

    // Readable anytime, no write side effect
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                MMD_OFS_FLASH_SIZE_INFO: o_reg_rdata <= flash_size_info;
                MMD_OFS_PROGRAM_PAGE_INDEX: o_reg_rdata <= {2'h0, page_index_bits_reg};
                default: o_reg_rdata <= '0;
            endcase
        end else begin
            o_reg_rdata <= '0;
        end
    end

    // Split code to first internal page
    always_comb begin
        case (i_offchip_split_sel)
            2'h0: split_first = MMD_SPLIT0_FIRST;
            2'h1: split_first = MMD_SPLIT1_FIRST;
            2'h2: split_first = MMD_SPLIT2_FIRST;
            default: split_first = MMD_SPLIT3_FIRST;
        endcase
    end
    assign win_internal = page_index_bits_reg >= split_first;

    assign access = i_cpu_rd || i_cpu_wr;
    assign reg_ofs = i_cpu_addr[9:0];
    assign reg_hit = i_cpu_addr[15:MMD_REG_BLK_LSB] == i_reg_base[15:MMD_REG_BLK_LSB];
    assign ram_hit = i_ram_en && ((i_cpu_addr & ~i_ram_mask) == (i_ram_base & ~i_ram_mask));
    assign ee_hit = i_ee_en && ((i_cpu_addr & ~i_ee_mask) == (i_ee_base & ~i_ee_mask));

    // Ports A and B removed when expanded
    // Port E removed with its enable when expanded
    // Port K removed with its enable in emulation mode
    always_comb begin
        port_removed = 1'b0;
        if (i_mode_expanded && (reg_ofs == MMD_OFS_PORTA || reg_ofs == MMD_OFS_PORTB
                || reg_ofs == MMD_OFS_DIRA || reg_ofs == MMD_OFS_DIRB)) begin
            port_removed = 1'b1;
        end
        if (i_mode_expanded && i_port_e_external_en
                && (reg_ofs == MMD_OFS_PORTE || reg_ofs == MMD_OFS_DIRE)) begin
            port_removed = 1'b1;
        end
        if (i_mode_periph && i_mode_special && reg_ofs < MMD_BUS_EXP_CNT) begin
            port_removed = 1'b1;
        end
        if (i_mode_emulation && i_port_k_external_en
                && (reg_ofs == MMD_OFS_PORTK || reg_ofs == MMD_OFS_DIRK)) begin
            port_removed = 1'b1;
        end
    end

    // Allocation code sets fixed flash blocks
    always_comb begin
        flash_hit = 1'b0;
        if (i_flash_en && i_flash_alloc_sel != MMD_ALLOC_NONE) begin
            case (i_cpu_addr[15:14])
                MMD_BLK_TOP: flash_hit = 1'b1;
                MMD_BLK_WINDOW: flash_hit = win_internal;
                MMD_BLK_MID: flash_hit = !i_flash_upper_half_only
                    && (i_flash_alloc_sel == MMD_ALLOC_48K || i_flash_alloc_sel == MMD_ALLOC_64K);
                default: flash_hit = !i_flash_upper_half_only
                    && i_flash_alloc_sel == MMD_ALLOC_64K;
            endcase
        end
        if (i_flash_alloc_sel == MMD_ALLOC_16K && i_cpu_addr[15:14] != MMD_BLK_TOP
                && i_cpu_addr[15:14] != MMD_BLK_WINDOW) begin
            flash_hit = 1'b0;
        end
    end

    always_comb begin
        sel_next = MMD_SEL_NONE;
        if (!access) begin
            sel_next = MMD_SEL_NONE;
        end else if (i_debug_firmware_space) begin
            sel_next = MMD_SEL_DBG;
        end else if (reg_hit) begin
            sel_next = port_removed ? MMD_SEL_EXT : MMD_SEL_REG;
        end else if (ram_hit) begin
            sel_next = MMD_SEL_RAM;
        end else if (ee_hit) begin
            sel_next = MMD_SEL_EE;
        end else if (flash_hit) begin
            sel_next = MMD_SEL_FLASH;
        end else if (i_mode_expanded) begin
            sel_next = MMD_SEL_EXT;
        end
    end

    assign emul_next = sel_next == MMD_SEL_FLASH && i_mode_emulation && i_port_k_external_en;
    assign xcs_next = sel_next == MMD_SEL_EXT && !emul_next && !(reg_hit && port_removed);

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sel_reg <= MMD_SEL_NONE;
            o_emulation_chip_sel_n <= 1'b1;
            o_external_chip_sel_n <= 1'b1;
        end else begin
            sel_reg <= sel_next;
            o_emulation_chip_sel_n <= !emul_next;
            o_external_chip_sel_n <= !xcs_next;
        end
    end
    assign o_sel = sel_reg;

    // Address and write data steered out
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_bus_addr <= '0;
            o_bus_wdata <= '0;
            o_bus_wr <= 1'b0;
            o_bus_page <= '0;
            swap_reg <= 1'b0;
            byte_reg <= 1'b0;
        end else begin
            o_bus_addr <= i_cpu_addr;
            o_bus_wr <= i_cpu_wr;
            o_bus_page <= page_index_bits_reg;
            swap_reg <= i_cpu_byte && !i_cpu_addr[0];
            byte_reg <= i_cpu_byte;
            if (i_cpu_byte) begin
                o_bus_wdata <= {i_cpu_wdata[7:0], i_cpu_wdata[7:0]};
            end else begin
                o_bus_wdata <= i_cpu_wdata;
            end
        end
    end

    always_comb begin
        case (rsel_reg)
            MMD_SEL_DBG: rmux = i_dbg_rdata;
            MMD_SEL_REG: rmux = i_regs_rdata;
            MMD_SEL_RAM: rmux = i_ram_rdata;
            MMD_SEL_EE: rmux = i_ee_rdata;
            MMD_SEL_FLASH: rmux = i_flash_rdata;
            MMD_SEL_EXT: rmux = i_ext_rdata;
            default: rmux = '0;
        endcase
    end

    // Data arrives the cycle after the select
    logic rswap_reg, rbyte_reg;
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            rsel_reg <= MMD_SEL_NONE;
            rswap_reg <= 1'b0;
            rbyte_reg <= 1'b0;
        end else begin
            rsel_reg <= sel_reg;
            rswap_reg <= swap_reg;
            rbyte_reg <= byte_reg;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_cpu_rdata <= '0;
        end else if (rswap_reg) begin
            o_cpu_rdata <= {8'h00, rmux[15:8]};
        end else if (rbyte_reg) begin
            o_cpu_rdata <= {8'h00, rmux[7:0]};
        end else begin
            o_cpu_rdata <= rmux;
        end
    end

    // Checks
    property p_size_ro;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_reg_rd && i_reg_addr == MMD_OFS_FLASH_SIZE_INFO |=>
            o_reg_rdata == {$past(i_flash_alloc_sel), 4'h0, $past(i_offchip_split_sel)};
    endproperty
    a_size_ro: assert property (p_size_ro) else $error("size info mismatch");

    property p_page_wr;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_reg_wr && i_reg_addr == MMD_OFS_PROGRAM_PAGE_INDEX && !i_far_wr && page_wr_ok
            |=> o_far_rdata == $past(i_reg_wdata[5:0]);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page write lost");

    property p_page_lock;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_far_wr && !(i_reg_wr && i_reg_addr == MMD_OFS_PROGRAM_PAGE_INDEX && page_wr_ok)
            |=> $stable(o_far_rdata);
    endproperty
    a_page_lock: assert property (p_page_lock) else $error("page changed");

    property p_far;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_far_wr |=> o_far_rdata == $past(i_far_wdata);
    endproperty
    a_far: assert property (p_far) else $error("far write lost");

    property p_onehot;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $onehot0(o_sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two selects");

    property p_dbg_first;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        access && i_debug_firmware_space |=> o_sel == MMD_SEL_DBG;
    endproperty
    a_dbg_first: assert property (p_dbg_first) else $error("debug not first");

    property p_cs_excl;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !(o_emulation_chip_sel_n == 1'b0 && o_external_chip_sel_n == 1'b0);
    endproperty
    a_cs_excl: assert property (p_cs_excl) else $error("both chip selects");

    property p_ecs;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !o_emulation_chip_sel_n |-> o_sel == MMD_SEL_FLASH && $past(i_mode_emulation);
    endproperty
    a_ecs: assert property (p_ecs) else $error("emulation select off flash");

    property p_swap;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_cpu_rd && i_cpu_byte && !i_cpu_addr[0] |=> ##1 rswap_reg ##1
            o_cpu_rdata == {8'h00, $past(rmux[15:8])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap lane wrong");

    property p_removed;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        access && reg_hit && port_removed && !i_debug_firmware_space
            |=> o_sel == MMD_SEL_EXT && o_external_chip_sel_n;
    endproperty
    a_removed: assert property (p_removed) else $error("removed port decode");

endmodule // mmd_top

// file: mmd_mem_model.sv
// Behavioural memories and peripherals answering the decode block's selects.
// Assumes registered selects; each source answers one cycle after its select.
`timescale 1ns/1ps
module mmd_mem_model (
    // Clock
    input wire logic i_clk_sys,
    // Bus from the decode block
    input wire logic [5:0] i_sel,
    input wire logic [15:0] i_bus_addr,
    // Read buses, index is the select bit
    output logic [5:0][15:0] o_rdata
);
    logic [15:0] cyc_reg = 16'h0000;
    logic [15:0] word;
    logic [5:0] sel_reg = 6'h00;
    logic [15:0] addr_reg = 16'h0000;

    // Synchronous sources: select and address taken at the edge
    always_ff @(posedge i_clk_sys) begin
        cyc_reg <= cyc_reg + 16'h0001;
        sel_reg <= i_sel;
        addr_reg <= i_bus_addr;
    end

    // Unselected sources show a changing pattern, never stale data
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            word = {4'hA, 4'(k), addr_reg[7:0]};
            o_rdata[k] = sel_reg[k] ? word : (~word ^ cyc_reg);
        end
    end
endmodule // mmd_mem_model

// file: tb_top.sv
// Self-checking bench for the memory map decode and paging block.
// Assumes the memory model answers every select one cycle later.
`timescale 1ns/1ps
module tb_top;
    import mmd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [1:0] i_flash_alloc_sel = 2'h0, i_offchip_split_sel = 2'h0;
    logic i_page_reset_high = 1'b0, i_far_wr = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic i_ram_en = 1'b1, i_ee_en = 1'b1, i_flash_en = 1'b1, i_debug_firmware_space = 1'b0;
    logic i_mode_expanded = 1'b0, i_mode_emulation = 1'b0, i_mode_periph = 1'b0;
    logic i_mode_special = 1'b0, i_port_e_external_en = 1'b0, i_port_k_external_en = 1'b0;
    logic i_flash_upper_half_only = 1'b0;
    logic [15:0] i_reg_base = 16'h0000, i_ram_base = 16'h0000, i_ram_mask = 16'h0FFF;
    logic [15:0] i_ee_base = 16'h0000, i_ee_mask = 16'h1FFF;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [5:0] i_far_wdata = 6'h00, o_far_rdata, o_bus_page, o_sel;
    logic [15:0] i_cpu_addr = 16'h0000, i_cpu_wdata = 16'h0000;
    logic [15:0] o_cpu_rdata, o_bus_addr, o_bus_wdata;
    logic i_cpu_wr = 1'b0, i_cpu_rd = 1'b0, i_cpu_byte = 1'b0, o_bus_wr;
    logic o_emulation_chip_sel_n, o_external_chip_sel_n;
    wire logic [15:0] i_dbg_rdata, i_regs_rdata, i_ram_rdata, i_ee_rdata, i_flash_rdata;
    wire logic [15:0] i_ext_rdata;
    wire logic [5:0][15:0] rdata;
    logic [5:0] thr [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
    int error_cnt = 0, cmp_count = 0;

    assign {i_ext_rdata, i_flash_rdata, i_ee_rdata, i_ram_rdata, i_regs_rdata, i_dbg_rdata} = rdata;

    mmd_top DUT (.*);

    mmd_mem_model partner (
        .i_clk_sys(i_clk_sys),
        .i_sel(o_sel),
        .i_bus_addr(o_bus_addr),
        .o_rdata(rdata)
    );

    always #50 i_clk_sys = ~i_clk_sys;

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic idle();
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        i_far_wr <= 1'b0;
        i_cpu_rd <= 1'b0;
        i_cpu_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_reg_wr <= w;
        i_reg_rd <= !w;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        idle();
        chk("reg rdata", 16'(e), 16'(o_reg_rdata));
    endtask

    task automatic far(input logic [5:0] pg);
        i_far_wr <= 1'b1;
        i_far_wdata <= pg;
        @(posedge i_clk_sys);
    endtask

    // Mode vector: ram ee flash dbg exp emu periph special porte portk upperhalf
    task automatic setm(input logic [10:0] m);
        {i_ram_en, i_ee_en, i_flash_en, i_debug_firmware_space, i_mode_expanded, i_mode_emulation,
            i_mode_periph, i_mode_special, i_port_e_external_en, i_port_k_external_en,
            i_flash_upper_half_only} <= m;
    endtask

    task automatic rst(input logic hi);
        i_page_reset_high <= hi;
        i_nrst <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        chk("page reset", hi ? 16'h003C : 16'h0000, 16'(o_far_rdata));
    endtask

    // Select, chip selects and read data of one CPU read
    task automatic dec(input logic [10:0] m, input logic [1:0] al, input logic [5:0] pg,
                       input logic [15:0] a, input logic [5:0] es, input logic [1:0] cs);
        setm(m);
        i_flash_alloc_sel <= al;
        i_cpu_byte <= 1'b0;
        far(pg);
        i_cpu_rd <= 1'b1;
        i_cpu_addr <= a;
        @(posedge i_clk_sys);
        idle();
        chk("sel", 16'(es), 16'(o_sel));
        chk("chip sels", 16'(cs), 16'({o_emulation_chip_sel_n, o_external_chip_sel_n}));
        chk("bus addr", a, o_bus_addr);
        chk("bus page", 16'(pg), 16'(o_bus_page));
        idle();
        idle();
        for (int k = 0; k < 6; k++) begin
            if (es[k]) chk("cpu rdata", {4'hA, 4'(k), a[7:0]}, o_cpu_rdata);
        end
    endtask

    task automatic dp(input logic w, input logic b, input logic [15:0] a, input logic [15:0] e);
        i_cpu_rd <= !w;
        i_cpu_wr <= w;
        i_cpu_byte <= b;
        i_cpu_addr <= a;
        i_cpu_wdata <= 16'h1234;
        @(posedge i_clk_sys);
        idle();
        chk("bus wr", 16'(w), 16'(o_bus_wr));
        if (w) chk("bus wdata", e, o_bus_wdata);
        idle();
        idle();
        if (!w) chk("cpu rdata", e, o_cpu_rdata);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            i_flash_alloc_sel <= 2'(i);
            i_offchip_split_sel <= 2'(3 - i);
            rd(8'h00, {2'(i), 4'h0, 2'(3 - i)});
        end
        bus(1'b1, 8'h00, 8'hFF);
        rd(8'h00, 8'hC0);
        idle();
        chk("rdata idle", 16'h0000, 16'(o_reg_rdata));
        rd(8'h05, 8'h00);
        bus(1'b1, 8'h01, 8'hC5);
        chk("page early", 16'h0000, 16'(o_far_rdata));
        bus(1'b0, 8'h01, 8'h00);
        chk("page", 16'h0005, 16'(o_far_rdata));
        idle();
        chk("page read", 16'h0005, 16'(o_reg_rdata));
        i_far_wr <= 1'b1;
        i_far_wdata <= 6'h12;
        bus(1'b1, 8'h01, 8'h21);
        idle();
        chk("far wins", 16'h0012, 16'(o_far_rdata));
        far(6'h3F);
        idle();
        chk("far page", 16'h003F, 16'(o_far_rdata));
        rst(1'b1);
        bus(1'b1, 8'h01, 8'h05);
        idle();
        chk("locked page", 16'h003C, 16'(o_far_rdata));
        setm(11'h708);
        bus(1'b1, 8'h01, 8'h05);
        idle();
        chk("special page", 16'h0005, 16'(o_far_rdata));
        rst(1'b0);
    endtask

    task automatic t_decode();
        dec(11'h700, 2'h3, 6'h00, 16'h0010, MMD_SEL_REG, 2'b11);
        dec(11'h780, 2'h3, 6'h00, 16'h0010, MMD_SEL_DBG, 2'b11);
        dec(11'h700, 2'h3, 6'h00, 16'h0800, MMD_SEL_RAM, 2'b11);
        dec(11'h300, 2'h3, 6'h00, 16'h0800, MMD_SEL_EE, 2'b11);
        dec(11'h400, 2'h3, 6'h00, 16'h1800, MMD_SEL_NONE, 2'b11);
        dec(11'h700, 2'h3, 6'h00, 16'h2000, MMD_SEL_FLASH, 2'b11);
        dec(11'h701, 2'h3, 6'h00, 16'h2000, MMD_SEL_NONE, 2'b11);
        dec(11'h700, 2'h1, 6'h00, 16'h4000, MMD_SEL_NONE, 2'b11);
        dec(11'h700, 2'h2, 6'h00, 16'h4000, MMD_SEL_FLASH, 2'b11);
        dec(11'h700, 2'h0, 6'h00, 16'hC000, MMD_SEL_NONE, 2'b11);
        dec(11'h700, 2'h3, 6'h37, 16'h8000, MMD_SEL_NONE, 2'b11);
        dec(11'h762, 2'h3, 6'h37, 16'h9000, MMD_SEL_EXT, 2'b10);
        dec(11'h762, 2'h3, 6'h00, 16'h0000, MMD_SEL_EXT, 2'b11);
        dec(11'h744, 2'h3, 6'h00, 16'h0008, MMD_SEL_EXT, 2'b11);
        dec(11'h740, 2'h3, 6'h00, 16'h0008, MMD_SEL_REG, 2'b11);
        dec(11'h718, 2'h3, 6'h00, 16'h000F, MMD_SEL_EXT, 2'b11);
        dec(11'h718, 2'h3, 6'h00, 16'h0010, MMD_SEL_REG, 2'b11);
        dec(11'h762, 2'h3, 6'h00, 16'h0032, MMD_SEL_EXT, 2'b11);
        dec(11'h760, 2'h3, 6'h00, 16'h0032, MMD_SEL_REG, 2'b11);
        dec(11'h762, 2'h3, 6'h00, 16'hC000, MMD_SEL_FLASH, 2'b01);
        dec(11'h760, 2'h3, 6'h00, 16'hC000, MMD_SEL_FLASH, 2'b11);
        dec(11'h600, 2'h3, 6'h00, 16'hC000, MMD_SEL_NONE, 2'b11);
        for (int s = 0; s < 4; s++) begin
            i_offchip_split_sel <= 2'(s);
            dec(11'h700, 2'h3, thr[s], 16'h8000, MMD_SEL_FLASH, 2'b11);
            if (s < 3) dec(11'h762, 2'h3, thr[s] - 6'h01, 16'hA000, MMD_SEL_EXT, 2'b10);
        end
        dec(11'h700, 2'h3, 6'h00, 16'hC000, MMD_SEL_FLASH, 2'b11);
        dp(1'b0, 1'b0, 16'hC002, 16'hA402);
        dp(1'b0, 1'b1, 16'hC002, 16'h00A4);
        dp(1'b0, 1'b1, 16'hC003, 16'h0003);
        dp(1'b1, 1'b0, 16'hC004, 16'h1234);
        dp(1'b1, 1'b1, 16'hC005, 16'h3434);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        rst(1'b0);
        t_regs();
        t_decode();
        test_done();
    end

    // Whole run is a few hundred cycles
    initial begin
        #500000;
        error_cnt++;
        test_done();
    end
endmodule // tb_top
